// *** rtl/cdc_level_sync.sv ***
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
module cdc_level_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;

   // first stage is read only by the second stage
   always_comb begin
      meta_d = d;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= meta_d;
         q <= meta_q;
      end
   end
endmodule : cdc_level_sync

// *** rtl/cdc_pulse_sync.sv ***
// toggle based crossing of single-cycle events
`timescale 1ns/1ps
module cdc_pulse_sync (
   input wire logic src_clk,
   input wire logic src_rst_n,
   input wire logic src_pulse,
   input wire logic dst_clk,
   input wire logic dst_rst_n,
   output logic dst_pulse
);
   logic tog_q;
   logic tog_d;
   logic [2:0] dst_q;
   logic [2:0] dst_d;

   // source flips a level per event so no event is too short to see
   always_comb begin
      tog_d = tog_q ^ src_pulse;
   end

   always_ff @(posedge src_clk or negedge src_rst_n) begin
      if (!src_rst_n) begin
         tog_q <= 1'b0;
      end else begin
         tog_q <= tog_d;
      end
   end

   // dst_q[0] feeds only dst_q[1]; the edge is found on the later stages
   always_comb begin
      dst_d = {dst_q[1], dst_q[0], tog_q};
   end

   always_ff @(posedge dst_clk or negedge dst_rst_n) begin
      if (!dst_rst_n) begin
         dst_q <= 3'h0;
      end else begin
         dst_q <= dst_d;
      end
   end

   assign dst_pulse = dst_q[2] ^ dst_q[1];
endmodule : cdc_pulse_sync

// *** rtl/i2c_bus_line_control.sv ***
// bus line control register of a two-wire bus interface, ahb-lite slave and link side
//
// What this block does
// - clock line monitor reads live scl level
// - data out changes only with guard 0
// - data out bit reads held output level
// - data out 0 drives low, 1 releases
// - busy write needs start/stop guard 0
// - stop condition clears bus busy flag
// - start condition sets bus busy flag
// - busy write 0 stops, 1 starts
// - unassigned bits 0 and 2 read 1
// - start/stop generation only in master mode
`timescale 1ns/1ps
`include "line_ctl_regs.svh"
module i2c_bus_line_control (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic link_clk,
   input wire line_ctl_pkg::bus_pins_s pins,
   output logic sda_o,
   output logic sda_oe
);
   import line_ctl_pkg::*;

   localparam logic [7:0] CTRL_RST_VAL = `LINE_CTRL_RESET;
   localparam logic [7:0] MODE_RST_VAL = `LINE_MODE_RESET;

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   ahb_phase_s phase_q;
   ahb_phase_s phase_d;
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;
   logic hreadyout_q;
   logic hresp_q;
   logic manual_out_q;
   logic manual_out_d;
   logic master_en_q;
   logic master_en_d;
   logic ctl_rst_q;
   logic ctl_rst_d;
   logic start_req_q;
   logic start_req_d;
   logic stop_req_q;
   logic stop_req_d;
   line_status_s stat_h;
   logic addr_acc;
   logic ctrl_wr;
   logic mode_wr;

   // zero wait states: every transfer is taken on the edge that sees hready high
   assign addr_acc = hsel & htrans[1] & hready;
   assign ctrl_wr = phase_q.valid & phase_q.write & (phase_q.idx == `LINE_CTRL_IDX);
   assign mode_wr = phase_q.valid & phase_q.write & (phase_q.idx == `LINE_MODE_IDX);

   // address capture and read data; unmapped reads return zero
   always_comb begin
      phase_d.valid = addr_acc & (haddr[31:12] == `UPPER_ADDR_ZERO);
      phase_d.write = hwrite;
      phase_d.idx = haddr[11:2];
      hrdata_d = 32'h0000_0000;
      if (addr_acc & ~hwrite & phase_d.valid) begin
         if (phase_d.idx == `LINE_CTRL_IDX) begin
            hrdata_d[`BIT_RSV0] = 1'b1;
            hrdata_d[`BIT_CTL_RST] = 1'b0;
            hrdata_d[`BIT_RSV2] = 1'b1;
            hrdata_d[`BIT_SCL_MON] = stat_h.scl;
            hrdata_d[`BIT_SDA_GUARD] = 1'b1;
            hrdata_d[`BIT_SDA_OUT] = manual_out_q;
            hrdata_d[`BIT_SS_GUARD] = 1'b1;
            hrdata_d[`BIT_BUSY] = stat_h.busy;
         end else if (phase_d.idx == `LINE_MODE_IDX) begin
            hrdata_d[`BIT_MASTER] = master_en_q;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_q <= '0;
         hrdata_q <= 32'h0000_0000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         hrdata_q <= hrdata_d;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hrdata = hrdata_q;
   assign hresp = hresp_q;

   // ----------------------------------------------------------------
   // register writes and request pulses
   // ----------------------------------------------------------------
   // guarded fields only move when the companion guard bit is written 0
   always_comb begin
      manual_out_d = manual_out_q;
      master_en_d = master_en_q;
      ctl_rst_d = 1'b0;
      start_req_d = 1'b0;
      stop_req_d = 1'b0;
      if (ctrl_wr) begin
         ctl_rst_d = hwdata[`BIT_CTL_RST];
         if (!hwdata[`BIT_SDA_GUARD]) begin
            manual_out_d = hwdata[`BIT_SDA_OUT];
         end
         if (!hwdata[`BIT_SS_GUARD] && master_en_q) begin
            start_req_d = hwdata[`BIT_BUSY];
            stop_req_d = ~hwdata[`BIT_BUSY];
         end
      end
      if (mode_wr) begin
         master_en_d = hwdata[`BIT_MASTER];
      end
   end

   // control reset only reaches the link side; registers are not in its path
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         manual_out_q <= CTRL_RST_VAL[`BIT_SDA_OUT];
         master_en_q <= MODE_RST_VAL[`BIT_MASTER];
         ctl_rst_q <= 1'b0;
         start_req_q <= 1'b0;
         stop_req_q <= 1'b0;
      end else begin
         manual_out_q <= manual_out_d;
         master_en_q <= master_en_d;
         ctl_rst_q <= ctl_rst_d;
         start_req_q <= start_req_d;
         stop_req_q <= stop_req_d;
      end
   end

   // ----------------------------------------------------------------
   // crossings between the register side and the link side
   // ----------------------------------------------------------------
   logic [1:0] link_rst_q;
   logic link_rst_n;
   logic start_l;
   logic stop_l;
   logic ctl_rst_l;
   logic manual_out_l;
   logic manual_low_l;
   bus_pins_s pins_l;
   logic busy_q;
   logic [1:0] stat_raw_h;

   // reset is asserted at once and released in step with the link clock
   always_ff @(posedge link_clk or negedge hresetn) begin
      if (!hresetn) begin
         link_rst_q <= 2'b00;
      end else begin
         link_rst_q <= {link_rst_q[0], 1'b1};
      end
   end
   assign link_rst_n = link_rst_q[1];

   cdc_pulse_sync u_start (.src_clk(hclk), .src_rst_n(hresetn), .src_pulse(start_req_q),
      .dst_clk(link_clk), .dst_rst_n(link_rst_n), .dst_pulse(start_l));
   cdc_pulse_sync u_stop (.src_clk(hclk), .src_rst_n(hresetn), .src_pulse(stop_req_q),
      .dst_clk(link_clk), .dst_rst_n(link_rst_n), .dst_pulse(stop_l));
   cdc_pulse_sync u_ctl_rst (.src_clk(hclk), .src_rst_n(hresetn), .src_pulse(ctl_rst_q),
      .dst_clk(link_clk), .dst_rst_n(link_rst_n), .dst_pulse(ctl_rst_l));
   // carried inverted so the synchroniser's zero reset means released, not a low pulse on sda
   cdc_level_sync #(.W(1)) u_out_l (.clk(link_clk), .rst_n(link_rst_n),
      .d(~manual_out_q), .q(manual_low_l));
   assign manual_out_l = ~manual_low_l;
   cdc_level_sync #(.W(2)) u_pins_l (.clk(link_clk), .rst_n(link_rst_n),
      .d(pins), .q(pins_l));
   // scl pin is sampled straight into the register side so the monitor is live
   cdc_level_sync #(.W(2)) u_stat_h (.clk(hclk), .rst_n(hresetn),
      .d({busy_q, pins.scl_in}), .q(stat_raw_h));
   assign stat_h = stat_raw_h;

   // ----------------------------------------------------------------
   // link side: condition detection and start/stop generation
   // ----------------------------------------------------------------
   gen_state_e gen_q;
   gen_state_e gen_d;
   bus_pins_s prev_q;
   logic busy_d;
   logic sda_oe_q;
   logic sda_oe_d;
   logic sda_o_q;
   logic start_det;
   logic stop_det;
   logic gen_low;

   // sda edges while scl stays high mark bus conditions
   assign start_det = pins_l.scl_in & prev_q.scl_in & prev_q.sda_in & ~pins_l.sda_in;
   assign stop_det = pins_l.scl_in & prev_q.scl_in & ~prev_q.sda_in & pins_l.sda_in;

   // generator holds sda low from a start until a stop is asked for
   always_comb begin
      gen_d = gen_q;
      busy_d = busy_q;
      if (start_det) begin
         busy_d = 1'b1;
      end else if (stop_det | ctl_rst_l) begin
         // a start seen on the pins wins over a clear in the same cycle
         busy_d = 1'b0;
      end
      case (gen_q)
         GEN_IDLE: begin
            if (start_l) begin
               gen_d = GEN_START;
            end else if (stop_l) begin
               gen_d = GEN_STOP;
            end
         end
         GEN_START: begin
            if (!pins_l.sda_in) begin
               gen_d = GEN_HELD;
            end
         end
         GEN_HELD: begin
            if (stop_l) begin
               gen_d = GEN_STOP;
            end else if (start_l) begin
               gen_d = GEN_START;
            end
         end
         GEN_STOP: begin
            gen_d = GEN_IDLE;
         end
         default: begin
            gen_d = GEN_IDLE;
         end
      endcase
      // hang-up recovery clears the generator state here and the busy flag above
      if (ctl_rst_l) begin
         gen_d = GEN_IDLE;
      end
   end

   assign gen_low = (gen_q == GEN_START) | (gen_q == GEN_HELD) | (gen_q == GEN_STOP);

   // sda is open drain: low when asked, otherwise released to the pull-up
   always_comb begin
      sda_oe_d = gen_low | ~manual_out_l;
   end

   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         gen_q <= GEN_IDLE;
         busy_q <= 1'b0;
         prev_q <= 2'b11;
         sda_oe_q <= 1'b0;
         sda_o_q <= 1'b0;
      end else begin
         gen_q <= gen_d;
         busy_q <= busy_d;
         prev_q <= pins_l;
         sda_oe_q <= sda_oe_d;
         sda_o_q <= 1'b0;
      end
   end

   assign sda_o = sda_o_q;
   assign sda_oe = sda_oe_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence stop_drive_s;
      (gen_q == GEN_STOP) ##1 (gen_q == GEN_IDLE);
   endsequence

   chk_ctl_rst_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
      ctl_rst_q |=> !ctl_rst_q) else $error("control reset longer than one cycle");
   chk_ctl_rst_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctl_rst_q && !mode_wr) |=> $stable(master_en_q)) else $error("control reset changed mode");
   chk_data_out_guarded: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_wr && hwdata[`BIT_SDA_GUARD]) |=> $stable(manual_out_q)) else $error("guarded data out changed");
   chk_data_out_written: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_wr && !hwdata[`BIT_SDA_GUARD]) |=> manual_out_q == $past(hwdata[`BIT_SDA_OUT]))
      else $error("data out not written");
   chk_ss_guarded: assert property (@(posedge hclk) disable iff (!hresetn)
      (ctrl_wr && hwdata[`BIT_SS_GUARD]) |=> !(start_req_q || stop_req_q)) else $error("guarded busy write acted");
   chk_master_only: assert property (@(posedge hclk) disable iff (!hresetn)
      (start_req_q || stop_req_q) |-> $past(master_en_q)) else $error("start/stop outside master mode");
   chk_scl_monitor: assert property (@(posedge hclk) disable iff (!hresetn)
      (addr_acc && !hwrite && phase_d.valid && phase_d.idx == `LINE_CTRL_IDX)
      |=> hrdata_q[`BIT_SCL_MON] == $past(stat_h.scl) && hrdata_q[`BIT_RSV0] && hrdata_q[`BIT_RSV2])
      else $error("monitor or reserved bits wrong");
   chk_start_busy: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      start_det |=> busy_q) else $error("start did not set busy");
   chk_stop_busy: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (stop_det && !start_det) |=> !busy_q) else $error("stop did not clear busy");
   chk_stop_release: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (stop_drive_s and (manual_out_l [*2])) |=> !sda_oe_q) else $error("stop did not release sda");
   chk_sda_release: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (!gen_low && manual_out_l) |=> !sda_oe_q) else $error("sda driven while released");

endmodule : i2c_bus_line_control

// *** shared/line_ctl_pkg.sv ***
// types shared by the bus line control block
package line_ctl_pkg;

   // captured address phase of an ahb-lite transfer
   typedef struct packed {
      logic valid;
      logic write;
      logic [9:0] idx;
   } ahb_phase_s;

   // two-wire bus pin levels as seen at the pads
   typedef struct packed {
      logic scl_in;
      logic sda_in;
   } bus_pins_s;

   // link-side busy flag and the scl pin level reported to the bus side
   typedef struct packed {
      logic busy;
      logic scl;
   } line_status_s;

   // start/stop generator states
   typedef enum logic [3:0] {
      GEN_IDLE = 4'b0001,
      GEN_START = 4'b0010,
      GEN_HELD = 4'b0100,
      GEN_STOP = 4'b1000
   } gen_state_e;

endpackage : line_ctl_pkg

// *** shared/line_ctl_regs.svh ***
// register offsets, field positions and reset values of the bus line control block
`ifndef LINE_CTL_REGS_SVH
`define LINE_CTL_REGS_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define LINE_CTRL_IDX 10'h0b9
`define LINE_MODE_IDX 10'h0c0
`define UPPER_ADDR_ZERO 20'h0_0000

// ----------------------------------------------------------------
// bus_line_control_two fields
// ----------------------------------------------------------------
`define BIT_RSV0 0
`define BIT_CTL_RST 1
`define BIT_RSV2 2
`define BIT_SCL_MON 3
`define BIT_SDA_GUARD 4
`define BIT_SDA_OUT 5
`define BIT_SS_GUARD 6
`define BIT_BUSY 7
`define LINE_CTRL_RESET 8'h3d

// ----------------------------------------------------------------
// line mode register fields
// ----------------------------------------------------------------
`define BIT_MASTER 0
`define LINE_MODE_RESET 8'h00

`endif

// *** testbench/bus_far_side.sv ***
// far side of the two-wire bus: other devices plus the sda pull-up
`timescale 1ns/1ps
module bus_far_side (
   input wire logic link_clk,
   input wire logic sda_o,
   input wire logic sda_oe,
   output line_ctl_pkg::bus_pins_s pins,
   output logic sda_line
);
   import line_ctl_pkg::*;

   // ------------------------------------------------------------
   // line state
   // ------------------------------------------------------------
   logic scl_q = 1'b1;
   logic pull_q = 1'b0;

   // wired-and with a pull-up, so a released line reads high, never a stale level
   always_comb begin
      sda_line = (sda_oe ? sda_o : 1'b1) & ~pull_q;
      pins.scl_in = scl_q;
      pins.sda_in = sda_line;
   end

   // ------------------------------------------------------------
   // actions of another device
   // ------------------------------------------------------------
   task automatic set_scl(input logic v);
      @(posedge link_clk);
      scl_q <= v;
   endtask : set_scl

   // start by another master: sda falls while scl stays high
   task automatic other_start();
      set_scl(1'b1);
      repeat (2) @(posedge link_clk);
      pull_q <= 1'b1;
      repeat (2) @(posedge link_clk);
   endtask : other_start

   // stop by another master: sda rises while scl stays high
   task automatic other_stop();
      set_scl(1'b1);
      repeat (2) @(posedge link_clk);
      pull_q <= 1'b0;
      repeat (2) @(posedge link_clk);
   endtask : other_stop
endmodule : bus_far_side

// *** testbench/i2c_bus_line_control_bench.sv ***
// self-checking bench of the bus line control block
`timescale 1ns/1ps
`include "line_ctl_regs.svh"
`define CHECK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
$display("ERROR %s expected %h seen %h", what, exp, got); end end
module i2c_bus_line_control_bench;
   import line_ctl_pkg::*;

   // ------------------------------------------------------------
   // signals and clocks
   // ------------------------------------------------------------
   localparam logic [31:0] CTRL_ADDR = {`UPPER_ADDR_ZERO, `LINE_CTRL_IDX, 2'b00};
   localparam logic [31:0] MODE_ADDR = {`UPPER_ADDR_ZERO, `LINE_MODE_IDX, 2'b00};
   localparam logic [31:0] HOLE_ADDR = 32'h0000_0010;
   logic hclk = 1'b0;
   logic link_clk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   bus_pins_s pins;
   logic sda_o;
   logic sda_oe;
   int miscompares = 0;
   int n_checks = 0;

   // periods of 100 ns and 160 ns line up only every 800 ns, so phases drift in between
   always #50 hclk = ~hclk;
   always #80 link_clk = ~link_clk;

   i2c_bus_line_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .link_clk(link_clk), .pins(pins), .sda_o(sda_o), .sda_oe(sda_oe));

   bus_far_side far (.link_clk(link_clk), .sda_o(sda_o), .sda_oe(sda_oe), .pins(pins), .sda_line());

   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb_xfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] unused;
      ahb_xfer(1'b1, a, d, unused);
   endtask : wr

   // polls the control register, bounded, until the masked bits settle
   task automatic expect_ctl(input string what, input logic [7:0] mask, input logic [7:0] exp);
      logic [31:0] rd;
      int n;
      n = 0;
      do begin
         ahb_xfer(1'b0, CTRL_ADDR, 32'h0000_0000, rd);
         n++;
      end while (((rd[7:0] & mask) !== exp) && n < 40);
      `CHECK(what, exp, rd[7:0] & mask)
   endtask : expect_ctl

   // waits, bounded, for the sda wire to reach a level
   task automatic line_is(input string what, input logic exp);
      int n;
      n = 0;
      while (far.sda_line !== exp && n < 80) begin
         @(posedge hclk);
         n++;
      end
      `CHECK(what, exp, far.sda_line)
   endtask : line_is

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values();
      logic [31:0] rd;
      ahb_xfer(1'b0, CTRL_ADDR, 32'h0, rd);
      `CHECK("ctrl after reset", 32'h0000_007d, rd)
      ahb_xfer(1'b0, MODE_ADDR, 32'h0, rd);
      `CHECK("mode after reset", 32'h0000_0000, rd)
      wr(HOLE_ADDR, 32'h0000_00ff);
      ahb_xfer(1'b0, HOLE_ADDR, 32'h0, rd);
      `CHECK("unmapped read", 32'h0000_0000, rd)
      `CHECK("hresp", 1'b0, hresp)
      `CHECK("hreadyout", 1'b1, hreadyout)
   endtask : t_reset_values

   task automatic t_scl_monitor();
      far.set_scl(1'b0);
      expect_ctl("scl low", 8'h08, 8'h00);
      far.set_scl(1'b1);
      expect_ctl("scl high", 8'h08, 8'h08);
   endtask : t_scl_monitor

   task automatic t_manual_sda();
      wr(CTRL_ADDR, 32'h0000_0050);
      expect_ctl("guarded data out", 8'h30, 8'h30);
      line_is("sda kept released", 1'b1);
      wr(CTRL_ADDR, 32'h0000_0040);
      expect_ctl("data out held low", 8'h30, 8'h10);
      line_is("sda driven low", 1'b0);
      wr(CTRL_ADDR, 32'h0000_0060);
      expect_ctl("data out held high", 8'h30, 8'h30);
      line_is("sda released", 1'b1);
      `CHECK("sda_oe released", 1'b0, sda_oe)
   endtask : t_manual_sda

   task automatic t_busy_detect();
      far.other_start();
      expect_ctl("busy after start", 8'h80, 8'h80);
      far.other_stop();
      expect_ctl("busy after stop", 8'h80, 8'h00);
   endtask : t_busy_detect

   task automatic t_generate();
      wr(CTRL_ADDR, 32'h0000_0090);
      repeat (30) @(posedge hclk);
      `CHECK("no start in slave mode", 1'b0, sda_oe)
      wr(MODE_ADDR, 32'h0000_0001);
      wr(CTRL_ADDR, 32'h0000_00d0);
      repeat (30) @(posedge hclk);
      `CHECK("no start with guard set", 1'b0, sda_oe)
      wr(CTRL_ADDR, 32'h0000_0090);
      line_is("start drives sda", 1'b0);
      `CHECK("sda_o level", 1'b0, sda_o)
      expect_ctl("busy after own start", 8'h80, 8'h80);
      wr(CTRL_ADDR, 32'h0000_0090);
      repeat (30) @(posedge hclk);
      `CHECK("repeated start keeps sda", 1'b0, far.sda_line)
      expect_ctl("busy after repeated start", 8'h80, 8'h80);
      wr(CTRL_ADDR, 32'h0000_0010);
      line_is("stop releases sda", 1'b1);
      expect_ctl("busy after own stop", 8'h80, 8'h00);
   endtask : t_generate

   task automatic t_ctl_reset();
      logic [31:0] rd;
      repeat (10) @(posedge hclk);
      wr(CTRL_ADDR, 32'h0000_0090);
      line_is("start before reset", 1'b0);
      expect_ctl("busy before reset", 8'h80, 8'h80);
      wr(CTRL_ADDR, 32'h0000_0052);
      line_is("generator reset", 1'b1);
      expect_ctl("busy after reset", 8'h80, 8'h00);
      expect_ctl("reset bit clear", 8'h37, 8'h35);
      ahb_xfer(1'b0, MODE_ADDR, 32'h0, rd);
      `CHECK("mode kept", 32'h0000_0001, rd)
   endtask : t_ctl_reset

   // ------------------------------------------------------------
   // closing, sequence and watchdog
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // two clock cycles of reset; the link side then leaves reset on its own synchronised edges
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      t_reset_values();
      t_scl_monitor();
      t_manual_sda();
      t_busy_detect();
      t_generate();
      t_ctl_reset();
      tally_and_finish();
   end

   // the sequence needs a few hundred cycles; 20000 means a hang
   initial begin
      #2_000_000;
      miscompares++;
      tally_and_finish();
   end
endmodule : i2c_bus_line_control_bench
